// File: core/gpac_consts.svh
`ifndef GPAC_CONSTS_SVH
`define GPAC_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte addresses on the APB
// ----------------------------------------------------------------
`define GPAC_ADDR_LATCH   8'h00
`define GPAC_ADDR_DIR     8'h04
`define GPAC_ADDR_WPU     8'h08
`define GPAC_ADDR_ANSEL   8'h0c
`define GPAC_ADDR_OPT     8'h10
`define GPAC_ADDR_IOC     8'h14
`define GPAC_ADDR_BITOP   8'h18

// ----------------------------------------------------------------
// Implemented bits of each register
// ----------------------------------------------------------------
`define GPAC_PORT_IMPL    8'hef
`define GPAC_LATCH_WMASK  8'hcf
`define GPAC_DIR_WMASK    8'hcf
`define GPAC_DIR_FIXED    8'h20
`define GPAC_WPU_MASK     8'h2f
`define GPAC_ANSEL_MASK   8'h0f
`define GPAC_IOC_MASK     8'hef

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GPAC_RST_LATCH    8'h00
`define GPAC_RST_DIR      8'hef
`define GPAC_RST_WPU      8'h2f
`define GPAC_RST_ANSEL    8'h0f
`define GPAC_RST_OPT      8'hff
`define GPAC_RST_IOC      8'h00

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define GPAC_OPT_PU_OFF   7
`define GPAC_BITOP_VAL    3
`define GPAC_SYNC_W       9
`define GPAC_ALT_W        9

`endif

// File: core/gpac_pkg.sv
`include "gpac_consts.svh"

package gpac_pkg;

  // ----------------------------------------------------------------
  // Whole state of the port controller
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  latch;    // Output latch
    logic [7:0]  dir;      // Direction, one = input
    logic [7:0]  wpu;      // Per-pin pull-up bits
    logic [7:0]  ansel;    // Analog select bits
    logic [7:0]  opt;      // Option byte, top bit kills software pull-ups
    logic [7:0]  ioc;      // Change-interrupt enables
    logic [7:0]  pin_out;  // Pin drive levels
    logic [7:0]  pin_oe_n; // Pin drivers, low = driving
    logic [7:0]  pin_pu;   // Weak pull-up controls
    logic [7:0]  ioc_en;   // Effective change enables
    logic [7:0]  dig_in;   // Digital input levels
    logic [31:0] prdata;   // Read data
    logic        pready;   // Access complete
    logic        pslverr;  // Unmapped access
  } gpac_state_t;

  // ----------------------------------------------------------------
  // Synchroniser state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`GPAC_SYNC_W-1:0] ff1; // Metastable stage
    logic [`GPAC_SYNC_W-1:0] ff2; // Settled stage
  } gpac_sync_t;

endpackage : gpac_pkg

// File: core/gpac_sync_if.sv
`timescale 1ns/1ps
`include "gpac_consts.svh"

// ----------------------------------------------------------------
// Raw pin levels in, settled levels back
// ----------------------------------------------------------------
interface gpac_sync_if;
  logic [`GPAC_SYNC_W-1:0] raw;    // Asynchronous levels
  logic [`GPAC_SYNC_W-1:0] synced; // After two flops
  modport owner (output raw, input synced);
  modport stage (input raw, output synced);
endinterface : gpac_sync_if

// File: core/gpac_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two-flop synchroniser for pins and straps
// ----------------------------------------------------------------
module gpac_sync
  import gpac_pkg::*;
(
  // Clock and reset
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  input  wire logic CE,
  // Level carrier
  gpac_sync_if.stage sif
);

  gpac_sync_t st_q; // Registered state
  gpac_sync_t st_d; // Next state

  // First stage is read only by the second
  always_comb begin
    st_d = st_q;
    if (CE) begin
      st_d.ff1 = sif.raw;
      st_d.ff2 = st_q.ff1;
    end
  end

  // State register
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sif.synced = st_q.ff2;

endmodule : gpac_sync

// File: core/gpac_port.sv
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "gpac_consts.svh"

module gpac_port
  import gpac_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Port pins
  input  wire logic [7:0]  PIN_IN,
  output logic      [7:0]  PIN_OUT,
  output logic      [7:0]  PIN_OE_N,
  output logic      [7:0]  PIN_PU,
  // Configuration strap
  input  wire logic        EXT_RESET_SEL,
  // Alternate functions
  input  wire logic [8:0]  ALT_EN,
  input  wire logic [8:0]  ALT_OUT,
  // Peripheral side
  output logic      [7:0]  DIG_IN,
  output logic      [7:0]  IOC_EN
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Register index from byte address, 7 when unmapped
  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h7;
    if (a[1:0] == 2'h0 && a[7:5] == 3'h0 && a[4:2] != 3'h7) begin
      r = a[4:2];
    end
    return r;
  endfunction : reg_idx

  // Highest enabled function wins, else the port latch
  function automatic logic prio_mux(input logic       port_v,
                                    input logic [1:0] en,
                                    input logic [1:0] val);
    logic r;
    r = port_v;
    if (en[1]) begin
      r = val[1];
    end else if (en[0]) begin
      r = val[0];
    end
    return r;
  endfunction : prio_mux

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  gpac_sync_if sif ();

  assign sif.raw = {EXT_RESET_SEL, PIN_IN};

  gpac_sync u_sync (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .CE      (CE),
    .sif     (sif)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  gpac_state_t st_q;      // Registered state
  gpac_state_t st_d;      // Next state
  logic [7:0]  pins;      // Settled pin levels
  logic        external_reset_pin_sel;  // Settled reset-pin strap
  logic [7:0]  rd_pins;   // Digital view of the pins
  logic [7:0]  drv_val;   // Winning output value per pin
  logic [7:0]  alt_act;   // Any alternate function on pin
  logic [7:0]  bitop_v;   // Read-modify-write result
  logic [7:0]  rd_byte;   // Selected read byte
  logic        setup_ok;  // First access cycle
  logic        commit;    // Completing access cycle
  logic        pu_glob;   // Global pull-up permission

  assign pins     = sif.synced[7:0];
  assign external_reset_pin_sel = sif.synced[8];

  // ----------------------------------------------------------------
  // Pin read path
  // ----------------------------------------------------------------

  // Analog pins and the missing pin read zero
  always_comb begin
    rd_pins = pins & ~st_q.ansel & `GPAC_PORT_IMPL;
  end

  // ----------------------------------------------------------------
  // Output priority per pin
  // ----------------------------------------------------------------

  // Pin 3 has no alternate; pin 5 never drives
  always_comb begin
    drv_val    = st_q.latch;
    alt_act    = 8'h00;
    drv_val[0] = prio_mux(st_q.latch[0], {1'b0, ALT_EN[0]},
                          {1'b0, ALT_OUT[0]});
    drv_val[1] = prio_mux(st_q.latch[1], {1'b0, ALT_EN[1]},
                          {1'b0, ALT_OUT[1]});
    drv_val[2] = prio_mux(st_q.latch[2], ALT_EN[3:2],
                          ALT_OUT[3:2]);
    drv_val[5] = prio_mux(st_q.latch[5], ALT_EN[5:4],
                          ALT_OUT[5:4]);
    drv_val[6] = prio_mux(st_q.latch[6], ALT_EN[7:6],
                          ALT_OUT[7:6]);
    drv_val[7] = prio_mux(st_q.latch[7], {1'b0, ALT_EN[8]},
                          {1'b0, ALT_OUT[8]});
    alt_act[0] = ALT_EN[0];
    alt_act[1] = ALT_EN[1];
    alt_act[2] = |ALT_EN[3:2];
    alt_act[5] = |ALT_EN[5:4];
    alt_act[6] = |ALT_EN[7:6];
    alt_act[7] = ALT_EN[8];
  end

  // ----------------------------------------------------------------
  // Read-modify-write of one bit
  // ----------------------------------------------------------------

  // Reads the pins, alters one bit, writes all back to the latch.
  // An analog pin reads zero here, so its latch bit gets cleared:
  // this matches the port's known read-modify-write hazard.
  always_comb begin
    bitop_v = rd_pins;
    bitop_v[PWDATA[2:0]] = PWDATA[`GPAC_BITOP_VAL];
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------

  // Unimplemented bits come back as zero
  always_comb begin
    case (reg_idx(PADDR))
      3'h0: rd_byte = rd_pins;
      3'h1: rd_byte = st_q.dir | `GPAC_DIR_FIXED;
      3'h2: rd_byte = st_q.wpu;
      3'h3: rd_byte = st_q.ansel;
      3'h4: rd_byte = st_q.opt;
      3'h5: rd_byte = st_q.ioc;
      default: rd_byte = 8'h00;
    endcase
  end

  assign setup_ok = PSEL & PENABLE & ~st_q.pready;
  assign commit   = PSEL & PENABLE & st_q.pready;
  assign pu_glob  = ~st_q.opt[`GPAC_OPT_PU_OFF];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Everything holds while the clock enable is low
  always_comb begin
    st_d = st_q;
    if (CE) begin
      // One wait state, then the answer
      st_d.pready = setup_ok;
      if (setup_ok) begin
        st_d.prdata  = {24'h000000, rd_byte};
        st_d.pslverr = (reg_idx(PADDR) == 3'h7);
      end
      // Writes land on the completing edge only
      if (commit && PWRITE) begin
        case (reg_idx(PADDR))
          3'h0: begin
            // Whole-byte write, pin five bit dropped
            st_d.latch = PWDATA[7:0] & `GPAC_LATCH_WMASK;
          end
          3'h1: begin
            st_d.dir = (PWDATA[7:0] & `GPAC_DIR_WMASK)
                       | `GPAC_DIR_FIXED;
          end
          3'h2: begin
            st_d.wpu = PWDATA[7:0] & `GPAC_WPU_MASK;
          end
          3'h3: begin
            st_d.ansel = PWDATA[7:0] & `GPAC_ANSEL_MASK;
          end
          3'h4: begin
            st_d.opt = PWDATA[7:0];
          end
          3'h5: begin
            st_d.ioc = PWDATA[7:0] & `GPAC_IOC_MASK;
          end
          3'h6: begin
            st_d.latch = bitop_v & `GPAC_LATCH_WMASK;
          end
          default: begin
            st_d.latch = st_q.latch;
          end
        endcase
      end
      // Drivers: direction decides, analog select does not
      // The absent pin four is never driven either
      st_d.pin_oe_n = st_q.dir | `GPAC_DIR_FIXED | ~`GPAC_PORT_IMPL;
      st_d.pin_out  = drv_val;
      // Open drain: only ever sinks, released for a one
      st_d.pin_out[7]  = 1'b0;
      st_d.pin_oe_n[7] = st_q.dir[7] | drv_val[7];
      // Pull-ups on pins 0-3 need every condition
      // Global permission is copied to all four bits, not zero-extended
      st_d.pin_pu = {4'h0, {4{pu_glob}} & st_q.dir[3:0] & st_q.wpu[3:0]
                     & ~st_q.ansel[3:0] & ~alt_act[3:0]};
      // Pin five pull-up is the strap's alone
      st_d.pin_pu[5] = external_reset_pin_sel;
      // Analog pins lose digital input and change detect
      st_d.dig_in = rd_pins;
      st_d.ioc_en = st_q.ioc & ~st_q.ansel;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Analog on, pull-ups off, change enables off at reset
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q          <= '0;
      st_q.latch    <= `GPAC_RST_LATCH;
      st_q.dir      <= `GPAC_RST_DIR;
      st_q.wpu      <= `GPAC_RST_WPU;
      st_q.ansel    <= `GPAC_RST_ANSEL;
      st_q.opt      <= `GPAC_RST_OPT;
      st_q.ioc      <= `GPAC_RST_IOC;
      st_q.pin_oe_n <= 8'hff;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign PRDATA   = st_q.prdata;
  assign PREADY   = st_q.pready;
  assign PSLVERR  = st_q.pslverr;
  assign PIN_OUT  = st_q.pin_out;
  assign PIN_OE_N = st_q.pin_oe_n;
  assign PIN_PU   = st_q.pin_pu;
  assign DIG_IN   = st_q.dig_in;
  assign IOC_EN   = st_q.ioc_en;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // Push-pull drivers track last cycle's direction
  a_dir_drive_en: assert property (
    ##1 (PIN_OE_N & 8'h4f) == ($past(st_q.dir) & 8'h4f))
    else $error("pin driver does not follow direction");

  // Input-only pin never drives, direction stays one
  a_pin5_input: assert property (
    PIN_OE_N[5] && st_q.dir[5])
    else $error("pin five driven or direction cleared");

  // Analog pins read zero over the bus
  a_analog_rd_zero: assert property (
    (PREADY && PSEL && !PWRITE && PADDR == `GPAC_ADDR_LATCH)
      |-> ((PRDATA[7:0] & st_q.ansel) == 8'h00))
    else $error("analog pin read as one");

  // Pull-up only when direction, pull-up bit and digital select held a cycle earlier
  a_pullup_gate: assert property (
    ##1 ((PIN_PU[3:0] & ~($past(st_q.dir[3:0]) & $past(st_q.wpu[3:0])
      & ~$past(st_q.ansel[3:0]))) == 4'h0))
    else $error("pull-up on without permission");

  // Global control off means no software pull-ups
  a_pullup_global: assert property (
    $past(st_q.opt[`GPAC_OPT_PU_OFF]) && $past(CE) |-> PIN_PU[3:0] == 4'h0)
    else $error("pull-up on while globally disabled");

  // No pull-ups on pins 4, 6 and 7
  a_pullup_none: assert property (
    PIN_PU[7:6] == 2'h0 && PIN_PU[4] == 1'b0)
    else $error("pull-up on a pin without one");

  // Open-drain pin never drives high
  a_od_pin7: assert property (
    !PIN_OE_N[7] |-> !PIN_OUT[7])
    else $error("pin seven driven high");

  // Analog pins never raise change enables
  a_ioc_analog: assert property (
    ##1 ((IOC_EN[3:0] & $past(st_q.ansel[3:0])) == 4'h0))
    else $error("change enable on analog pin");

  // Pin five pull-up copies the strap
  a_pin5_pullup: assert property (
    $past(CE) |-> PIN_PU[5] == $past(external_reset_pin_sel))
    else $error("pin five pull-up wrong");

  // Latch write leaves pin five bit clear
  a_latch_pin5: assert property (
    st_q.latch[5] == 1'b0 && st_q.latch[4] == 1'b0)
    else $error("latch holds an unimplemented bit");

  // Answer is a single-cycle pulse two cycles into a transfer
  a_ready_pulse: assert property (
    PREADY |=> !PREADY)
    else $error("ready held for more than one cycle");

endmodule : gpac_port

// File: bench/gpac_board.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Board circuitry hanging on the port pins
// ----------------------------------------------------------------
module gpac_board (
  // Clock for the floating-line pattern
  input  wire logic       clk,
  // Device side of the pins
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pin_pu,
  // Outside drivers on the board
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // Resolved pin levels
  output logic      [7:0] pin_lvl
);
  logic float_q = 1'b0; // Undriven lines toggle so they never look stable

  // Noise source for floating lines
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end

  // Device driver first, then the board driver, then pull-ups, else noise
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) begin
        pin_lvl[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_lvl[i] = ext_val[i];
      end else if (pin_pu[i] || i == 7) begin
        pin_lvl[i] = 1'b1; // Pin seven has a resistor to the supply on the board
      end else begin
        pin_lvl[i] = float_q;
      end
    end
  end
endmodule : gpac_board

// File: bench/gpac_port_tb_top.sv
`timescale 1ns/1ps
`include "gpac_consts.svh"

// ----------------------------------------------------------------
// Comparison helper
// ----------------------------------------------------------------
`define CHK(got, exp, msg) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("CHECK FAILED t=%0t %s", $time, msg); \
  end \
end

module gpac_port_tb_top
  import gpac_pkg::*;
  ;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        sys_clk = 1'b0;    // 200 MHz
  logic        rst_n   = 1'b0;    // Held low for four cycles
  logic        psel    = 1'b0;    // APB master controls
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;            // APB answer
  logic        pready;
  logic        pslverr;
  logic [7:0]  pin_lvl;           // Resolved pins
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe_n;
  logic [7:0]  pin_pu;
  logic [7:0]  dig_in;
  logic [7:0]  ioc_en;
  logic        ce      = 1'b1;    // Clock enable
  logic        strap   = 1'b0;    // Pin five as external reset pin
  logic [8:0]  alt_en  = 9'h000;  // Alternate function requests
  logic [8:0]  alt_out = 9'h000;
  logic [7:0]  ext_en  = 8'h20;   // Board drives the input-only pin high
  logic [7:0]  ext_val = 8'h20;
  int          errors   = 0;
  int          n_checks = 0;
  logic [31:0] rd;                // Last read data
  logic        err;               // Last error flag

  // Clock
  always #2.5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Design and board
  // ----------------------------------------------------------------
  gpac_port i_dut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .CE(ce),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PIN_IN(pin_lvl), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .PIN_PU(pin_pu),
    .EXT_RESET_SEL(strap), .ALT_EN(alt_en), .ALT_OUT(alt_out),
    .DIG_IN(dig_in), .IOC_EN(ioc_en)
  );

  gpac_board i_board (
    .clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pu(pin_pu),
    .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic end_of_test();
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // One APB transfer; the answer is taken at the edge that sees pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++; // A stuck slave would hang the run
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Lets synchronisers and output flops catch up, then steps off the edge
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  logic [7:0] ra [6] = '{`GPAC_ADDR_DIR, `GPAC_ADDR_WPU, `GPAC_ADDR_ANSEL,
                         `GPAC_ADDR_OPT, `GPAC_ADDR_IOC, `GPAC_ADDR_BITOP};
  logic [7:0] rv [6] = '{8'hef, 8'h2f, 8'h0f, 8'hff, 8'h00, 8'h00};
  int         pm [9] = '{0, 1, 2, 2, 5, 5, 6, 6, 7}; // Pin of each alternate function

  initial begin
    int   p;
    logic vb;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    settle();
    // Reset state of registers and pins
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      `CHK({err, rd}, {9'h000, 16'h0, rv[i]}, "reset value")
    end
    `CHK({pin_pu, ioc_en, pin_oe_n & 8'hef}, 24'h0000ef, "pins after reset")
    // Unmapped and misaligned places refuse
    apb(1'b0, 8'h1c, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0}, "unmapped read")
    apb(1'b1, 8'h02, 32'hff);
    `CHK(err, 1'b1, "misaligned write")
    // All outputs; the input-only direction bit stays set
    apb(1'b1, `GPAC_ADDR_DIR, 32'h0);
    apb(1'b0, `GPAC_ADDR_DIR, 32'h0);
    `CHK(rd, 32'h20, "direction readback")
    settle();
    `CHK({pin_out, pin_oe_n & 8'hef}, 16'h0020, "drivers on")
    // Latch write goes to the pins, analog pins read zero
    apb(1'b1, `GPAC_ADDR_LATCH, 32'hff);
    settle();
    `CHK({pin_out, pin_oe_n & 8'hef}, 16'h4fa0, "latch drive")
    apb(1'b0, `GPAC_ADDR_LATCH, 32'h0);
    `CHK({rd, dig_in}, {32'he0, 8'he0}, "pin read")
    // Bit set reads pins back, so analog pins lose their latch ones
    apb(1'b1, `GPAC_ADDR_BITOP, 32'h0e);
    settle();
    `CHK(pin_out, 8'h40, "bit op write back")
    apb(1'b1, `GPAC_ADDR_LATCH, 32'hff);
    // Change enables masked by analog select
    apb(1'b1, `GPAC_ADDR_IOC, 32'hff);
    apb(1'b0, `GPAC_ADDR_IOC, 32'h0);
    `CHK(rd, 32'hef, "change enables")
    settle();
    `CHK(ioc_en, 8'he0, "analog change mask")
    apb(1'b1, `GPAC_ADDR_ANSEL, 32'h0);
    settle();
    `CHK(ioc_en, 8'hef, "digital change")
    apb(1'b0, `GPAC_ADDR_LATCH, 32'h0);
    `CHK({rd, dig_in}, {32'hef, 8'hef}, "digital pin read")
    // Pull-ups
    apb(1'b1, `GPAC_ADDR_DIR, 32'hff);
    apb(1'b1, `GPAC_ADDR_WPU, 32'hff);
    apb(1'b0, `GPAC_ADDR_WPU, 32'h0);
    `CHK(rd, 32'h2f, "pull-up bits")
    settle();
    `CHK(pin_pu, 8'h00, "global pull-up off")
    apb(1'b1, `GPAC_ADDR_OPT, 32'h7f);
    settle();
    `CHK(pin_pu, 8'h0f, "pull-ups on")
    apb(1'b1, `GPAC_ADDR_ANSEL, 32'h05);
    settle();
    `CHK(pin_pu, 8'h0a, "analog kills pull-up")
    apb(1'b1, `GPAC_ADDR_ANSEL, 32'h0);
    apb(1'b1, `GPAC_ADDR_DIR, 32'hfd);
    settle();
    `CHK(pin_pu, 8'h0d, "output kills pull-up")
    apb(1'b1, `GPAC_ADDR_DIR, 32'hff);
    @(posedge sys_clk);
    alt_en <= 9'h001;
    strap  <= 1'b1;
    settle();
    `CHK(pin_pu, 8'h2e, "alternate use and reset pin")
    apb(1'b1, `GPAC_ADDR_OPT, 32'hff);
    settle();
    `CHK(pin_pu, 8'h20, "reset pin pull-up fixed")
    // Alternate outputs do not drive while direction is set
    @(posedge sys_clk);
    alt_en  <= 9'h1ff;
    alt_out <= 9'h1ff;
    strap   <= 1'b0;
    settle();
    `CHK(pin_oe_n & 8'hef, 8'hef, "no drive as input")
    // Priority: the highest enabled function owns the pin
    apb(1'b1, `GPAC_ADDR_DIR, 32'h0);
    apb(1'b1, `GPAC_ADDR_LATCH, 32'h0);
    for (int i = 0; i < 9; i++) begin
      for (int v = 0; v < 2; v++) begin
        vb = 1'(v);
        p = pm[i];
        @(posedge sys_clk);
        alt_en  <= 9'((1 << (i + 1)) - 1);
        alt_out <= vb ? 9'(1 << i) : ~9'(1 << i);
        settle();
        if (p == 5) begin
          `CHK(pin_oe_n[5], 1'b1, "input-only pin driven")
        end else if (p == 7) begin
          `CHK({pin_out[7], pin_oe_n[7]}, {1'b0, vb}, "open drain priority")
        end else begin
          `CHK({pin_out[p], pin_oe_n[p]}, {vb, 1'b0}, "output priority")
        end
      end
    end
    // Clock enable low freezes the drivers, high lets them follow again
    @(posedge sys_clk);
    ce      <= 1'b0;
    alt_out <= 9'h000;
    settle();
    `CHK(pin_oe_n[7], 1'b1, "driver moved with clock enable low")
    @(posedge sys_clk);
    ce <= 1'b1;
    settle();
    `CHK(pin_oe_n[7], 1'b0, "open drain stuck after enable returns")
    end_of_test();
  end
endmodule : gpac_port_tb_top
